/* File: rtl/acc_bit_ops.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acc_ops_map.svh"

module acc_bit_ops
  import acc_ops_pkg::*;
#(
  parameter int W = `ACC_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Operation request from the sequencer
  input wire logic op_valid,
  input wire op_t op_code,
  input wire logic [W-1:0] operand,
  // Accumulator and status
  output logic [W-1:0] acc_reg,
  output logic op_done_reg,
  output logic operand_range_error_flag,
  output logic bcd_error_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lowest set bit index; zero for an empty accumulator
  function automatic logic [W-1:0] lowest_index(input logic [W-1:0] v);
    logic [W-1:0] idx;
    idx = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = W'(i);
      end
    end
    return idx;
  endfunction

  // Repeated division by 32 until the value is in range
  function automatic logic [`DECODE_GROUP_BITS-1:0] reduce_index(input logic [W-1:0] v);
    logic [W-1:0] t;
    t = v;
    for (int i = 0; i < W / `DECODE_GROUP_BITS + 1; i++) begin
      if (t >= W'(`DECODE_RANGE)) begin
        t = t >> `DECODE_GROUP_BITS;
      end
    end
    return t[`DECODE_GROUP_BITS-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Conversion datapath

  logic [W-1:0] to_bin;
  logic to_bin_bad;
  logic [W-1:0] to_bcd;
  logic to_bcd_over;

  bcd_convert #(
    .W(W)
  ) bcd_convert_i (
    .value(acc_reg),
    .to_bin(to_bin),
    .to_bin_bad(to_bin_bad),
    .to_bcd(to_bcd),
    .to_bcd_over(to_bcd_over)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next accumulator value

  logic [W-1:0] acc_next;
  logic many_set;

  // x & (x-1) is nonzero exactly when two or more bits are set
  assign many_set = |(acc_reg & (acc_reg - W'(1)));

  always_comb begin
    acc_next = acc_reg;
    case (op_code)
      load_op: begin
        acc_next = operand;
      end
      shift_right_op: begin
        if (operand >= W'(`SHIFT_CNT_MAX)) begin
          acc_next = '0;
        end else begin
          acc_next = acc_reg >> operand;
        end
      end
      priority_encode_op: begin
        acc_next = lowest_index(acc_reg);
      end
      one_hot_decode_op: begin
        acc_next = W'(1) << reduce_index(acc_reg);
      end
      decimal_to_binary_op: begin
        acc_next = to_bin;
      end
      binary_to_bcd_op: begin
        acc_next = to_bcd;
      end
      complement_op: begin
        acc_next = ~acc_reg;
      end
      default: begin
        acc_next = acc_reg;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator

  // Single-cycle update so the next request always sees the finished result
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acc_reg <= `ACC_RESET;
    end else if (op_valid) begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      op_done_reg <= 1'b0;
    end else begin
      op_done_reg <= op_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: only the owning operations touch each flag

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      operand_range_error_flag <= 1'b0;
    end else if (op_valid && op_code == priority_encode_op) begin
      operand_range_error_flag <= many_set;
    end
  end

  // Overflow past eight digits is reported here too; result keeps low digits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bcd_error_flag <= 1'b0;
    end else if (op_valid && op_code == decimal_to_binary_op) begin
      bcd_error_flag <= to_bin_bad;
    end else if (op_valid && op_code == binary_to_bcd_op) begin
      bcd_error_flag <= to_bcd_over;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_shift_zero_fill: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == shift_right_op && operand != '0 && operand < W'(`SHIFT_CNT_MAX)
      |=> acc_reg[W-1] == 1'b0 && acc_reg == ($past(acc_reg) >> $past(operand)))
    else $error("shift right result wrong");

  chk_shift_full_clear: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == shift_right_op && operand == W'(`SHIFT_CNT_MAX) |=> acc_reg == '0)
    else $error("shift by 32 did not clear");

  chk_encode_top_bit: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == priority_encode_op && acc_reg == 32'h8000_0000
      |=> acc_reg == 32'h0000_001F && !operand_range_error_flag)
    else $error("encode of bit 31 not 1F");

  chk_encode_low_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == priority_encode_op && acc_reg <= 32'h0000_0001 |=> acc_reg == '0)
    else $error("encode of 0 or 1 not zero");

  chk_encode_many_flag: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == priority_encode_op && $countones(acc_reg) > 1
      |=> operand_range_error_flag && acc_reg < W'(`DECODE_RANGE))
    else $error("multi-bit encode flag missing");

  chk_flag_held: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !(op_valid && op_code == priority_encode_op)
      |=> operand_range_error_flag == $past(operand_range_error_flag))
    else $error("range flag changed by other operation");

  chk_decode_one_hot: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == one_hot_decode_op && acc_reg == 32'h0000_000F
      |=> acc_reg == 32'h0000_8000)
    else $error("decode of F not bit 15");

  chk_decode_reduce: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == one_hot_decode_op |=> $onehot(acc_reg))
    else $error("decode not one-hot");

  // Independent of the loop: one division suffices below 1024
  chk_decode_div_once: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == one_hot_decode_op
      && acc_reg >= 32'h0000_0020 && acc_reg < 32'h0000_0400
      |=> acc_reg == 32'h0000_0001 << $past(acc_reg[9:5]))
    else $error("decode above 31 not reduced");

  chk_invert_all: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == complement_op |=> acc_reg == ~$past(acc_reg))
    else $error("invert wrong");

  chk_idle_hold: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !op_valid |=> acc_reg == $past(acc_reg) && !op_done_reg)
    else $error("accumulator changed while idle");

  chk_bcd_round_trip: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    op_valid && op_code == binary_to_bcd_op && acc_reg < 32'h05F5_E100
      ##1 op_valid && op_code == decimal_to_binary_op
      |=> acc_reg == $past(acc_reg, 2) && !bcd_error_flag)
    else $error("decimal round trip mismatch");

endmodule
`default_nettype wire

/* File: rtl/acc_ops_map.svh */
`ifndef ACC_OPS_MAP_SVH
`define ACC_OPS_MAP_SVH

// Datapath widths
`define ACC_WIDTH 32
`define SHIFT_CNT_MAX 32
`define DECODE_GROUP_BITS 5
`define DECODE_RANGE 32
`define BCD_DIGITS 8
`define BCD_WIDE_DIGITS 10
`define DECIMAL_LIMIT 9

// Timing: every operation completes on the edge that accepts it
`define OP_LATENCY_CYCLES 1

// Reset values
`define ACC_RESET 32'h0000_0000

`endif

/* File: rtl/acc_ops_pkg.sv */
package acc_ops_pkg;

  // Operation select, one-hot codes
  typedef enum logic [6:0] {
    load_op              = 7'h01,
    shift_right_op       = 7'h02,
    priority_encode_op   = 7'h04,
    one_hot_decode_op    = 7'h08,
    decimal_to_binary_op = 7'h10,
    binary_to_bcd_op     = 7'h20,
    complement_op        = 7'h40
  } op_t;

endpackage

/* File: rtl/bcd_convert.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acc_ops_map.svh"

module bcd_convert #(
  parameter int W = `ACC_WIDTH,
  parameter int DIGITS = `BCD_DIGITS,
  parameter int WIDE_DIGITS = `BCD_WIDE_DIGITS
) (
  // Value to convert
  input wire logic [W-1:0] value,
  // Decimal to binary
  output logic [W-1:0] to_bin,
  output logic to_bin_bad,
  // Binary to decimal
  output logic [W-1:0] to_bcd,
  output logic to_bcd_over
);

  always_comb begin
    logic [W-1:0] sum;
    logic [3:0] digit;
    logic bad;
    sum = '0;
    digit = '0;
    bad = 1'b0;
    for (int j = DIGITS - 1; j >= 0; j--) begin
      digit = value[4*j +: 4];
      if (digit > 4'(`DECIMAL_LIMIT)) begin
        bad = 1'b1;
      end
      sum = W'(sum * W'(10) + W'(digit));
    end
    to_bin = sum;
    to_bin_bad = bad;
  end

  // Shift-and-add-three; wide scratch so overflow beyond 8 digits is seen
  always_comb begin
    logic [4*WIDE_DIGITS-1:0] dec;
    dec = '0;
    for (int i = W - 1; i >= 0; i--) begin
      for (int j = 0; j < WIDE_DIGITS; j++) begin
        if (dec[4*j +: 4] >= 4'h5) begin
          dec[4*j +: 4] = dec[4*j +: 4] + 4'h3;
        end
      end
      dec = {dec[4*WIDE_DIGITS-2:0], value[i]};
    end
    to_bcd = dec[W-1:0];
    to_bcd_over = |dec[4*WIDE_DIGITS-1:W];
  end

endmodule
`default_nettype wire

/* File: tb/acc_bit_ops_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_bit_ops_tb;
  import acc_ops_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid;
  op_t op_code;
  logic [31:0] operand;
  logic [31:0] acc_reg;
  logic op_done_reg;
  logic operand_range_error_flag;
  logic bcd_error_flag;
  int error_cnt = 0;
  int n_tests = 0;

  always #2 ref_clk = ~ref_clk;

  op_sequencer seq_i (.ref_clk(ref_clk), .op_valid(op_valid), .op_code(op_code),
    .operand(operand));
  acc_bit_ops acc_bit_ops_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_code(op_code), .operand(operand), .acc_reg(acc_reg), .op_done_reg(op_done_reg),
    .operand_range_error_flag(operand_range_error_flag), .bcd_error_flag(bcd_error_flag));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Load a start value, run one op, judge the accumulator
  task automatic pair(input op_t code, input logic [31:0] init, input logic [31:0] arg,
      input logic [31:0] exp);
    seq_i.issue(load_op, init);
    seq_i.issue(code, arg);
    chk("acc_reg", exp, acc_reg);
    chk("op_done_reg", 32'h0000_0001, {31'd0, op_done_reg});
  endtask

  task automatic rng(input logic exp);
    chk("operand_range_error_flag", {31'd0, exp}, {31'd0, operand_range_error_flag});
  endtask

  task automatic bcdf(input logic exp);
    chk("bcd_error_flag", {31'd0, exp}, {31'd0, bcd_error_flag});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("acc_reg", 32'h0000_0000, acc_reg);
    chk("op_done_reg", 32'h0000_0000, {31'd0, op_done_reg});
    rng(1'b0);
    bcdf(1'b0);
  endtask

  task automatic t_shift;
    pair(shift_right_op, 32'hF000_000F, 32'h0000_000A, 32'h003C_0000);
    seq_i.issue(shift_right_op, 32'h0000_0012);
    chk("acc_reg", 32'h0000_000F, acc_reg);
    pair(shift_right_op, 32'h8000_0001, 32'h0000_0000, 32'h8000_0001);
    pair(shift_right_op, 32'h8000_0001, 32'h0000_001F, 32'h0000_0001);
    pair(shift_right_op, 32'hFFFF_FFFF, 32'h0000_0020, 32'h0000_0000);
  endtask

  task automatic t_encode;
    pair(priority_encode_op, 32'h8000_0000, 32'h0000_0000, 32'h0000_001F);
    rng(1'b0);
    pair(priority_encode_op, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000);
    pair(priority_encode_op, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    pair(priority_encode_op, 32'h0000_0A00, 32'h0000_0000, 32'h0000_0009);
    rng(1'b1);
    pair(complement_op, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF);
    rng(1'b1);
    pair(priority_encode_op, 32'h0000_0010, 32'h0000_0000, 32'h0000_0004);
    rng(1'b0);
  endtask

  task automatic t_decode;
    pair(one_hot_decode_op, 32'h0000_000F, 32'h0000_0000, 32'h0000_8000);
    pair(one_hot_decode_op, 32'h0000_001F, 32'h0000_0000, 32'h8000_0000);
    pair(one_hot_decode_op, 32'h0000_002F, 32'h0000_0000, 32'h0000_0002);
    pair(one_hot_decode_op, 32'h0000_1000, 32'h0000_0000, 32'h0000_0010);
  endtask

  task automatic t_convert;
    pair(decimal_to_binary_op, 32'h1234_5678, 32'h0000_0000, 32'h00BC_614E);
    bcdf(1'b0);
    pair(decimal_to_binary_op, 32'h0000_00A0, 32'h0000_0000, 32'h0000_0064);
    bcdf(1'b1);
    pair(binary_to_bcd_op, 32'h00BC_614E, 32'h0000_0000, 32'h1234_5678);
    bcdf(1'b0);
    // Nine digits: low eight kept, overflow reported
    pair(binary_to_bcd_op, 32'h05F5_E100, 32'h0000_0000, 32'h0000_0000);
    bcdf(1'b1);
    pair(complement_op, 32'h1234_5678, 32'h0000_0000, 32'hEDCB_A987);
    bcdf(1'b1);
    // Unknown code leaves the accumulator alone but still completes
    pair(op_t'(7'h00), 32'h1234_5678, 32'h0000_0000, 32'h1234_5678);
  endtask

  // Reset in mid-run with both flags raised
  task automatic t_mid_reset;
    pair(priority_encode_op, 32'h0000_0A00, 32'h0000_0000, 32'h0000_0009);
    @(negedge ref_clk);
    sys_rst = 1'b1;
    @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset();
  endtask

  // Back-to-back requests: each op reads the previous result
  task automatic t_burst;
    seq_i.burst(load_op, 32'hF000_000F, shift_right_op, 32'h0000_000A);
    chk("acc_reg", 32'h003C_0000, acc_reg);
    seq_i.issue(load_op, 32'h00BC_614E);
    seq_i.burst(binary_to_bcd_op, 32'h0000_0000, decimal_to_binary_op, 32'h0000_0000);
    chk("acc_reg", 32'h00BC_614E, acc_reg);
    bcdf(1'b0);
    chk("op_done_reg", 32'h0000_0001, {31'd0, op_done_reg});
    @(negedge ref_clk);
    chk("op_done_reg", 32'h0000_0000, {31'd0, op_done_reg});
  endtask

  task automatic results;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset();
    t_shift();
    t_encode();
    t_decode();
    t_convert();
    t_mid_reset();
    t_burst();
    results();
  end
endmodule
`default_nettype wire

/* File: tb/op_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module op_sequencer
  import acc_ops_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Request to the datapath
  output var logic op_valid,
  output var op_t op_code,
  output var logic [31:0] operand
);
  initial begin
    op_valid = 1'b0;
    op_code = load_op;
    operand = 32'h0000_0000;
  end

  // One request, held over one taking edge
  task automatic issue(input op_t code, input logic [31:0] val);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = code;
    operand = val;
    @(negedge ref_clk);
    op_valid = 1'b0;
    // Released operand must not look like the last one
    operand = ~val;
  endtask

  // Two requests on consecutive taking edges, strobe held high between
  task automatic burst(input op_t code_a, input logic [31:0] val_a, input op_t code_b,
      input logic [31:0] val_b);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = code_a;
    operand = val_a;
    @(negedge ref_clk);
    op_code = code_b;
    operand = val_b;
    @(negedge ref_clk);
    op_valid = 1'b0;
    operand = ~val_b;
  endtask
endmodule
`default_nettype wire
